/* core/adc_ctrl_pkg.sv */
// Constants, types and register map of the converter control block.
// Assumes a single 200 MHz clock and a synchronous active-low system reset.
package adc_ctrl_pkg;

   // Result layout: nominal code plus overrange bit on top
   localparam int CODE_W = 12;
   localparam int RAW_W  = 14;
   localparam int RES_W  = CODE_W + 1;

   localparam logic signed [RAW_W-1:0] FULL_SCALE = 14'sh0fff;
   localparam logic [CODE_W-1:0]       CODE_ONES  = 12'hfff;
   localparam logic [CODE_W-1:0]       CODE_ZERO  = 12'h000;
   localparam logic [CODE_W-1:0]       OFFSET_RST = 12'h000;

   // Conversion time, rounded up to whole clock cycles
   localparam int CLK_PERIOD_PS = 5000;
   localparam int CONV_TIME_NS  = 300;
   localparam int CONV_CYC      = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W         = $clog2(CONV_CYC + 1);
   typedef logic [CNT_W-1:0] cnt_t;
   localparam cnt_t CONV_LAST   = cnt_t'(CONV_CYC - 1);

   // Wishbone register byte offsets
   localparam int              ADR_W      = 4;
   localparam logic [ADR_W-1:0] REG_STATUS = 4'h0;
   localparam logic [ADR_W-1:0] REG_OFFSET = 4'h4;
   localparam logic [ADR_W-1:0] REG_RESULT = 4'h8;
   localparam logic [ADR_W-1:0] REG_CTRL   = 4'hc;

   // Status and control bit positions
   localparam int ST_BUSY_BIT   = 0;
   localparam int ST_HOLD_BIT   = 1;
   localparam int ST_PEND_BIT   = 2;
   localparam int ST_RSTPIN_BIT = 3;
   localparam int ST_BUFV_BIT   = 4;
   localparam int CTRL_START_BIT = 0;

   typedef enum {ST_IDLE, ST_CONV, ST_LATCH} conv_state_e;

   typedef struct packed {
      logic              over;
      logic [CODE_W-1:0] code;
   } result_s;

endpackage

/* core/result_fifo.sv */
// Small result buffer with valid/ready on both sides.
// Assumes one clock and synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
   parameter int W     = 13,
   parameter int DEPTH = 2
) (
   input  wire logic         clk_i,
   input  wire logic         resetn_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("result_fifo DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0]  mem_r [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [CW-1:0] count_r;
   logic          push;
   logic          pop;

   // Honest full and empty straight from the occupancy count
   assign in_ready_o  = (count_r != CW'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign out_data_o  = mem_r[rd_ptr_r];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Storage writes; no reset needed on the data words
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   // Pointers and count
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + PW'(1);
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + PW'(1);
         end
         if (push && !pop) begin
            count_r <= count_r + CW'(1);
         end else if (pop && !push) begin
            count_r <= count_r - CW'(1);
         end
      end
   end
endmodule
`default_nettype wire

/* core/adc_conv_ctrl.sv */
// Digital control of a successive-approximation converter: start, reset
// pin, clipping, output latch, offset register and Wishbone access.
// Assumes all pins are synchronous to clk_i; sample_i stands in for the
// comparator's raw signed result of the held input.
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module adc_conv_ctrl
   import adc_ctrl_pkg::*;
#(
   parameter int BUF_DEPTH = 2
) (
   input  wire logic                    clk_i,
   input  wire logic                    resetn_i,
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [ADR_W-1:0]        wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic [31:0]                  wb_dat_o,
   output logic                         wb_ack_o,
   input  wire logic                    adc_reset_n_i,
   input  wire logic                    convert_start_i,
   input  wire logic                    saturate_enable_i,
   input  wire logic                    op_select_a_i,
   input  wire logic                    op_select_b_i,
   input  wire logic signed [RAW_W-1:0] sample_i,
   input  wire logic                    cs_n_i,
   input  wire logic                    rd_n_i,
   input  wire logic                    write_i,
   input  wire logic [RES_W-1:0]        data_i,
   output logic [RES_W-1:0]             data_o,
   output logic                         data_oe_o,
   output logic                         busy_o,
   output logic                         track_hold_o,
   output result_s                      result_o,
   output logic                         result_valid_o,
   input  wire logic                    result_ready_i
);

   if (BUF_DEPTH < 2) begin : g_bad_buf
      $error("adc_conv_ctrl BUF_DEPTH must be at least 2");
   end

   conv_state_e              state_r;
   cnt_t                     cnt_r;
   logic signed [RAW_W-1:0]  held_r;
   result_s                  result_r;
   result_s                  out_reg_r;
   logic                     pend_r;
   logic [CODE_W-1:0]        offset_r;
   logic                     cs_prev_r;
   logic                     rst_prev_r;
   logic                     wr_prev_r;
   logic                     ack_r;
   logic [31:0]              dat_r;
   logic                     mode_two;
   logic                     start_fall;
   logic                     rst_fall;
   logic                     wr_fall;
   logic                     wb_req;
   logic                     wb_wr;
   logic                     soft_start;
   logic                     start_ok;
   logic                     conv_done;
   logic                     push;
   logic                     buf_in_ready;
   logic [31:0]              rd_word;

   // Mode two only when select b alone is high; all else runs mode one
   assign mode_two   = op_select_b_i & ~op_select_a_i;
   assign start_fall = cs_prev_r & ~convert_start_i;
   assign rst_fall   = rst_prev_r & ~adc_reset_n_i;
   assign wr_fall    = wr_prev_r & ~write_i & ~cs_n_i;
   assign wb_req     = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wb_wr      = wb_cyc_i & wb_stb_i & wb_we_i & ack_r; // Lands at the ack edge
   assign soft_start = wb_wr & (wb_adr_i == REG_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_START_BIT];
   assign conv_done  = (state_r == ST_CONV) && (cnt_r == '0);

   // A start with a result still waiting needs buffer room for it,
   // otherwise the edge is refused rather than losing a word
   assign start_ok = (start_fall | soft_start) & adc_reset_n_i
                     & (state_r == ST_IDLE) & (~pend_r | buf_in_ready);

   // Result enters the output register and the buffer together
   assign push = ((state_r == ST_LATCH) & buf_in_ready)
               | (start_ok & pend_r);

   // Pin side outputs
   assign busy_o       = (state_r == ST_IDLE);
   assign track_hold_o = (state_r == ST_CONV);
   assign data_o       = out_reg_r;
   assign data_oe_o    = ~cs_n_i & ~rd_n_i & ~write_i;
   assign wb_ack_o     = ack_r;
   assign wb_dat_o     = dat_r;

   // Saturate_enable or pass the raw result; overrange bit reports except on a negative result clipped to zero
   function automatic result_s saturate_enable_fn(input logic signed [RAW_W-1:0] raw,
                                       input logic sat);
      result_s r;
      r.over = 1'b0;
      r.code = raw[CODE_W-1:0];
      if (raw > FULL_SCALE) begin
         r.over = 1'b1;
         if (sat) begin
            r.code = CODE_ONES;
         end
      end else if (raw < 0) begin
         r.over = 1'b1;
         if (sat) begin
            r.over = 1'b0;
            r.code = CODE_ZERO;
         end
      end
      return r;
   endfunction

   // Edge detectors for the pin inputs
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cs_prev_r  <= 1'b1;
         rst_prev_r <= 1'b1;
         wr_prev_r  <= 1'b0;
      end else begin
         cs_prev_r  <= convert_start_i;
         rst_prev_r <= adc_reset_n_i;
         wr_prev_r  <= write_i;
      end
   end

   // Conversion sequencer; the reset pin overrides everything
   always_ff @(posedge clk_i) begin
      if (!resetn_i || !adc_reset_n_i) begin
         state_r <= ST_IDLE;
         cnt_r   <= '0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (start_ok) begin
                  state_r <= ST_CONV;
                  cnt_r   <= CONV_LAST;
               end
            end
            ST_CONV: begin
               if (cnt_r == '0) begin
                  state_r <= mode_two ? ST_IDLE : ST_LATCH;
               end else begin
                  cnt_r <= cnt_r - cnt_t'(1);
               end
            end
            ST_LATCH: begin
               if (buf_in_ready) begin
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Hold the input at the start edge, then form the result
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         held_r   <= '0;
         result_r <= '0;
      end else begin
         if (start_ok) begin
            held_r <= sample_i;
         end
         if (conv_done) begin
            result_r <= saturate_enable_fn(held_r, saturate_enable_i);
         end
      end
   end

   // Mode two keeps a finished result pending until the next start
   always_ff @(posedge clk_i) begin
      if (!resetn_i || !adc_reset_n_i) begin
         pend_r <= 1'b0;
      end else if (conv_done && mode_two) begin
         pend_r <= 1'b1;
      end else if (push) begin
         pend_r <= 1'b0;
      end
   end

   // Output register, read by the host over the data pins
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         out_reg_r <= '0;
      end else if (push) begin
         out_reg_r <= result_r;
      end
   end

   // Offset word: pin write wins over a bus write in the same cycle
   always_ff @(posedge clk_i) begin
      if (!resetn_i || rst_fall) begin
         offset_r <= OFFSET_RST;
      end else if (!adc_reset_n_i) begin
         offset_r <= offset_r;
      end else if (wr_fall) begin
         offset_r <= data_i[CODE_W-1:0];
      end else if (wb_wr && wb_adr_i == REG_OFFSET) begin
         if (wb_sel_i[0]) begin
            offset_r[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            offset_r[CODE_W-1:8] <= wb_dat_i[CODE_W-1:8];
         end
      end
   end

   // Register read mux; unmapped offsets read as zero
   always_comb begin
      rd_word = '0;
      unique case (wb_adr_i)
         REG_STATUS: begin
            rd_word[ST_BUSY_BIT]   = busy_o;
            rd_word[ST_HOLD_BIT]   = track_hold_o;
            rd_word[ST_PEND_BIT]   = pend_r;
            rd_word[ST_RSTPIN_BIT] = adc_reset_n_i;
            rd_word[ST_BUFV_BIT]   = result_valid_o;
         end
         REG_OFFSET: rd_word[CODE_W-1:0] = offset_r;
         REG_RESULT: rd_word[RES_W-1:0]  = out_reg_r;
         default:    rd_word = '0;
      endcase
   end

   // Classic Wishbone: one wait state, ack for every address
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ack_r <= 1'b0;
         dat_r <= '0;
      end else begin
         ack_r <= wb_req;
         if (wb_req && !wb_we_i) begin
            dat_r <= rd_word;
         end
      end
   end

   // Stream of latched results; in mode one a stalled reader holds busy low
   result_fifo #(
      .W     (RES_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .in_valid_i  (push),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (result_r),
      .out_valid_o (result_valid_o),
      .out_ready_i (result_ready_i),
      .out_data_o  (result_o)
   );

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_conv_run;
      (!busy_o && track_hold_o) [*8];
   endsequence

   sequence s_pin_low;
      !adc_reset_n_i [*3];
   endsequence

   a_start_enters_conv: assert property (start_ok |=> state_r == ST_CONV)
      else $error("start edge did not begin a conversion");

   a_hold_sample: assert property (start_ok |=> held_r == $past(sample_i))
      else $error("input not held at start edge");

   a_pin_reset_abort: assert property (rst_fall |=> busy_o && !track_hold_o)
      else $error("reset pin fall did not abort conversion");

   a_offset_clear: assert property (rst_fall |=> offset_r == OFFSET_RST)
      else $error("offset not cleared on reset pin fall");

   a_reset_held_idle: assert property (s_pin_low |-> state_r == ST_IDLE && !pend_r)
      else $error("block not idle while reset pin low");

   a_saturate_enable_passthru: assert property (conv_done && !saturate_enable_i
         |=> result_r.code == $past(held_r[CODE_W-1:0]))
      else $error("unclipped result altered");

   a_saturate_enable_high: assert property (conv_done && saturate_enable_i && held_r > FULL_SCALE
         |=> result_r == {1'b1, CODE_ONES})
      else $error("overrange not clipped to all ones");

   a_over_bit: assert property (conv_done && !saturate_enable_i && held_r < 0
         |=> result_r.over)
      else $error("overrange bit missing");

   a_busy_low_conv: assert property (start_ok |=> s_conv_run)
      else $error("busy not low during conversion");

   a_op_select_a_latch: assert property (state_r == ST_LATCH && !buf_in_ready && adc_reset_n_i
         |=> !busy_o)
      else $error("busy high before result latched");

   a_op_select_b_busy: assert property (conv_done && mode_two && adc_reset_n_i
         |=> busy_o && pend_r && $stable(out_reg_r))
      else $error("mode two completion handled wrongly");

   a_write_latch: assert property (wr_fall && adc_reset_n_i && rst_prev_r
         |=> offset_r == $past(data_i[CODE_W-1:0]))
      else $error("offset word not latched on write fall");

   a_no_start_reset: assert property (!adc_reset_n_i ##1 !adc_reset_n_i
         |-> state_r == ST_IDLE && !start_ok)
      else $error("conversion started while reset pin low");

endmodule
`default_nettype wire

/* dv/host_model.sv */
// Host on the parallel pins: start pulses, reset pin, offset writes, reads.
// Assumes its tasks are called one at a time from a single process.
`timescale 1ns/100ps
`default_nettype none
module host_model
   import adc_ctrl_pkg::*;
(
   input  wire logic             clk_i,
   output logic                  convert_start_o,
   output logic                  reset_n_o,
   output logic                  cs_n_o,
   output logic                  rd_n_o,
   output logic                  write_o,
   output logic [RES_W-1:0]      bus_o,
   input  wire logic [RES_W-1:0] bus_i
);
   // Idle levels; the released bus shows a pattern, never a held word
   initial begin
      convert_start_o = 1'b1;
      reset_n_o       = 1'b1;
      cs_n_o          = 1'b1;
      rd_n_o          = 1'b1;
      write_o         = 1'b0;
      bus_o           = 13'h0aaa;
   end
   // One low cycle on convert start
   task automatic start();
      @(posedge clk_i);
      convert_start_o <= 1'b0;
      @(posedge clk_i);
      convert_start_o <= 1'b1;
   endtask
   // Reset pin level; low pulse after power-up
   task automatic pin_reset(input logic lvl);
      @(posedge clk_i);
      reset_n_o <= lvl;
   endtask
   // Word under chip select first, then the write pulse whose fall latches
   task automatic write_word(input logic [RES_W-1:0] v);
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      bus_o  <= v;
      @(posedge clk_i);
      write_o <= 1'b1;
      @(posedge clk_i);
      write_o <= 1'b0;
      @(posedge clk_i);
      cs_n_o <= 1'b1;
      bus_o  <= ~v; // Released lines must not look held
   endtask
   // Read the output register through the pins; word taken at a rising edge
   task automatic read_word(output logic [RES_W-1:0] v);
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      rd_n_o <= 1'b0;
      @(posedge clk_i);
      v = bus_i;
      cs_n_o <= 1'b1;
      rd_n_o <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* dv/tb_adc_conversion_reset_control.sv */
// Self-checking bench of the converter control block.
// Assumes the host model drives the pins and the bench drives Wishbone.
`timescale 1ns/100ps
`default_nettype none
module tb_adc_conversion_reset_control;
   import adc_ctrl_pkg::*;
   typedef struct packed {
      logic signed [RAW_W-1:0] s;
      logic                    sat;
      logic [RES_W-1:0]        e;
   } row_s;
   logic                    clk_i;
   logic                    resetn_i;
   logic                    wb_cyc, wb_stb, wb_we;
   logic [ADR_W-1:0]        wb_adr;
   logic [3:0]              wb_sel;
   logic [31:0]             wb_wdat, rdat, wb_dat_o;
   logic                    wb_ack_o, busy_o, track_hold_o, data_oe_o;
   logic                    conv_start, pin_rst_n, cs_n, rd_n, wr;
   logic                    sat_en, op_a, op_b, result_valid_o, result_ready;
   logic signed [RAW_W-1:0] sample;
   logic [RES_W-1:0]        pin_dat, data_o;
   result_s                 result_o;
   row_s                    rows[7];
   int                      errors, compares;
   int                      cycles = 0;
   wire  [RES_W-1:0]        pin_bus = data_oe_o ? data_o : 'z;

   adc_conv_ctrl u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .adc_reset_n_i(pin_rst_n), .convert_start_i(conv_start),
      .saturate_enable_i(sat_en), .op_select_a_i(op_a), .op_select_b_i(op_b),
      .sample_i(sample), .cs_n_i(cs_n), .rd_n_i(rd_n), .write_i(wr),
      .data_i(pin_dat), .data_o(data_o), .data_oe_o(data_oe_o), .busy_o(busy_o),
      .track_hold_o(track_hold_o), .result_o(result_o),
      .result_valid_o(result_valid_o), .result_ready_i(result_ready));
   host_model u_host (.clk_i(clk_i), .convert_start_o(conv_start), .reset_n_o(pin_rst_n),
      .cs_n_o(cs_n), .rd_n_o(rd_n), .write_o(wr), .bus_o(pin_dat), .bus_i(pin_bus));

   // Clock, 5 ns period
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic test_done();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Classic cycle: hold until ack is sampled at a rising edge, release there
   task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= w;
      wb_adr  <= a;
      wb_wdat <= d;
      wb_sel  <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      check("wb ack", wb_ack_o, 1);
      rdat = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   // One conversion; n counts cycles with busy low, capped at 400
   task automatic conv(input logic signed [RAW_W-1:0] s, input logic sat, output int n);
      @(posedge clk_i);
      sample <= s;
      sat_en <= sat;
      u_host.start();
      n = 0;
      @(negedge clk_i);
      check("hold", track_hold_o, 1);
      while (busy_o === 1'b0 && n < 400) begin
         n++;
         @(negedge clk_i);
      end
   endtask

   // Hang guard, well above the expected run of about 1300 cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         errors++;
         test_done();
      end
   end

   initial begin
      int n;
      logic [RES_W-1:0] pin;
      result_s got[$];
      errors = 0;
      compares = 0;
      resetn_i = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = '0;
      wb_sel = '0;
      wb_wdat = '0;
      sat_en = 1'b0;
      op_a = 1'b1;
      op_b = 1'b0;
      sample = '0;
      result_ready = 1'b1;
      rows = '{'{14'sd100, 1'b0, 13'h0064}, '{14'sd4095, 1'b1, 13'h0fff},
               '{14'sd4096, 1'b1, 13'h1fff}, '{14'sd4096, 1'b0, 13'h1000},
               '{-14'sd1, 1'b1, 13'h0000}, '{-14'sd1, 1'b0, 13'h1fff},
               '{14'sd0, 1'b1, 13'h0000}};
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(negedge clk_i);
      check("idle busy", busy_o, 1);
      check("idle valid", result_valid_o, 0);
      u_host.pin_reset(1'b0);
      u_host.pin_reset(1'b1);
      // Ordinary conversions in mode one
      foreach (rows[i]) begin
         conv(rows[i].s, rows[i].sat, n);
         check("busy low", n, 61);
         u_host.read_word(pin);
         check("result", pin, rows[i].e);
      end
      // Mode two: latch waits for the next start
      @(posedge clk_i);
      op_a <= 1'b0;
      op_b <= 1'b1;
      conv(14'sd7, 1'b0, n);
      check("busy low m2", n, 60);
      check("not latched", data_o, 13'h0000);
      conv(14'sd9, 1'b0, n);
      check("latched", data_o, 13'h0007);
      // Offset by pins, then reset pin aborts and clears
      u_host.write_word(13'h0123);
      wb(1'b0, REG_OFFSET, 32'h0);
      check("offset", rdat, 32'h123);
      @(posedge clk_i);
      op_a <= 1'b1;
      op_b <= 1'b0;
      u_host.start();
      repeat (10) @(posedge clk_i);
      u_host.pin_reset(1'b0);
      repeat (3) @(negedge clk_i);
      check("abort busy", busy_o, 1);
      check("abort hold", track_hold_o, 0);
      wb(1'b0, REG_OFFSET, 32'h0);
      check("offset clr", rdat, 32'h0);
      wb(1'b0, REG_STATUS, 32'h0);
      check("status", rdat, 32'h1);
      u_host.start();
      repeat (20) @(negedge clk_i);
      check("start ignored", busy_o, 1);
      u_host.pin_reset(1'b1);
      // Register side: offset, unmapped, software start
      wb(1'b1, REG_OFFSET, 32'h0000_0abc);
      wb(1'b0, REG_OFFSET, 32'h0);
      check("offset wb", rdat, 32'h0abc);
      wb(1'b0, 4'h2, 32'h0);
      check("unmapped", rdat, 32'h0);
      sample <= 14'sd42;
      wb(1'b1, REG_CTRL, 32'h1);
      n = 0;
      @(negedge clk_i);
      check("sw busy", busy_o, 0);
      while (busy_o !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      wb(1'b0, REG_RESULT, 32'h0);
      check("sw result", rdat, 32'h02a);
      // Consumer stalls: third result waits, none is lost
      @(posedge clk_i);
      result_ready <= 1'b0;
      conv(14'sd1, 1'b0, n);
      conv(14'sd2, 1'b0, n);
      conv(14'sd3, 1'b0, n);
      check("stalled", n, 400);
      @(posedge clk_i);
      result_ready <= 1'b1;
      repeat (20) begin
         @(negedge clk_i);
         if (result_valid_o === 1'b1)
            got.push_back(result_o);
      end
      check("drained", got.size(), 3);
      for (int i = 0; i < 3; i++) begin
         check("stream", got[i], i + 1);
      end
      test_done();
   end
endmodule
`default_nettype wire
